// [rtl/lpt_pkg.sv]
package lpt_pkg;

  // lad field codes
  localparam logic [3:0] LAD_START = 4'h0;
  localparam logic [3:0] LAD_SYNC_READY = 4'h0;
  localparam logic [3:0] LAD_SYNC_SWAIT = 4'h5;
  localparam logic [3:0] LAD_SYNC_LWAIT = 4'h6;
  localparam logic [3:0] LAD_SYNC_ERR = 4'ha;
  localparam logic [3:0] LAD_TAR = 4'hf;

  // cycle type nibble, bits [3:2] type, bit 1 direction
  localparam logic [1:0] CYC_IO = 2'h0;
  localparam logic [1:0] CYC_MEM = 2'h1;
  localparam int CYC_DIR_BIT = 1;

  // nibble counts, as last index
  localparam logic [2:0] IO_ADDR_LAST = 3'h3;
  localparam logic [2:0] MEM_ADDR_LAST = 3'h7;
  localparam logic [2:0] DATA_LAST = 3'h1;
  localparam logic [2:0] TAR_LAST = 3'h1;

  // wait sync limits
  localparam logic [3:0] WAIT_MIN = 4'h2;
  localparam logic [3:0] WAIT_MAX = 4'h8;
  localparam logic [7:0] RDATA_TIMEOUT = 8'hff;

  // clock restart handshake, in lclk rising edges
  localparam logic [1:0] CK_HOLD_EDGES = 2'h2;
  localparam logic [1:0] CK_IDLE_CLOCKS = 2'h2;

  typedef enum logic [3:0] {
    LPT_IDLE,
    LPT_CYC,
    LPT_ADDR,
    LPT_WDATA,
    LPT_TAR_H,
    LPT_SYNC,
    LPT_RDATA,
    LPT_TAR_D,
    LPT_SKIP
  } lpt_state_t;

endpackage : lpt_pkg

// [rtl/lpt_sync.sv]
`timescale 1ns/10ps
`default_nettype none

module lpt_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // levels
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  // first stage feeds the second stage only
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      meta_r <= '0;
      q_r <= '0;
    end
    else
    begin
      meta_r <= d_i;
      q_r <= meta_r;
    end
  end

  assign q_o = q_r;

endmodule : lpt_sync

`default_nettype wire

// [rtl/lpt_target.sv]
// What this block does
// - accept host i/o cycles to reach the i/o mapped registers
// - accept host memory cycles to reach memory mapped registers and ram
// - only single byte i/o and memory reads and writes; ignore other cycles
// - at least two wait syncs before the ready sync
// - more wait syncs while the internal access has not completed
// - every wait sync is long wait, never short wait
// - a transaction ends within eight wait states
// - the error sync code is never driven
// - keep working when power-down toggles without a bus reset
// - power-down resets only the bus interface, not the rest
// - lad, serial irq and clock-run float during any reset or power-down
// - enable setting 0 disables serial irq and clock-run driving
// - enable setting 1 enables serial irq and clock-run restart
// - clock-run is open drain; high means clock stopped, low running
// - irq change or rising dma request while clock-run high drives clock-run low
// - hold clock-run low for two rising lclk edges, then release
// - never start driving clock-run while the clock generator holds it low
// - drive clock-run only after two deasserted clocks before the stop
// - change is any edge on any irq, seen without lclk
// - keep restarting the clock until the change is delivered
// - claim only i/o and memory cycles for own devices, leave others unanswered
`timescale 1ns/10ps
`default_nettype none

module lpt_target
  import lpt_pkg::*;
#(
  parameter int N_IRQ = 16
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // lpc pins
  input wire logic lclk_i,
  input wire logic lframe_n_i,
  input wire logic lreset_n_i,
  input wire logic lpcpd_n_i,
  input wire logic [3:0] lad_i,
  output logic [3:0] lad_o,
  output logic lad_oe_o,
  input wire logic clkrun_n_i,
  output logic clkrun_n_o,
  output logic clkrun_n_oe_o,
  output logic serirq_o,
  output logic serirq_oe_o,
  // chip side control
  input wire logic main_rail_rst_n_i,
  input wire logic serial_irq_enable_setting_i,
  input wire logic [N_IRQ-1:0] irq_i,
  input wire logic drq_i,
  input wire logic irq_delivered_i,
  input wire logic serirq_drive_i,
  input wire logic serirq_value_i,
  // internal register access
  output logic req_valid_o,
  output logic req_write_o,
  output logic req_mem_o,
  output logic [31:0] req_addr_o,
  output logic [7:0] req_wdata_o,
  input wire logic claim_i,
  input wire logic rsp_done_i,
  input wire logic [7:0] rsp_rdata_i
);

  typedef struct packed {
    lpt_state_t st;
    logic [2:0] cnt;
    logic mem;
    logic wr;
    logic [31:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [3:0] waits;
    logic req_valid;
    logic done;
    logic [3:0] lad;
    logic lad_oe;
    logic lclk_d;
    logic bus_rst;
    logic [N_IRQ-1:0] irq_d;
    logic drq_d;
    logic pending;
    logic ck_drive;
    logic [1:0] ck_edges;
    logic [1:0] ck_hi;
    logic sq_val;
    logic sq_oe;
  } lpt_regs_t;

  function automatic logic cyc_supported(input logic [3:0] nib);
    cyc_supported = (nib[3:2] == CYC_IO) || (nib[3:2] == CYC_MEM);
  endfunction : cyc_supported

  function automatic logic [2:0] addr_last(input logic mem);
    addr_last = mem ? MEM_ADDR_LAST : IO_ADDR_LAST;
  endfunction : addr_last

  lpt_regs_t r_r;
  lpt_regs_t r_nxt;

  logic lclk_s;
  logic lframe_n_s;
  logic lreset_n_s;
  logic lpcpd_n_s;
  logic clkrun_n_s;
  logic rail_n_s;
  logic [3:0] lad_s;
  logic lclk_rise;
  logic lclk_fall;
  logic bus_rst_now;
  logic sirq_en;
  logic change;

  // every pin level crosses two flops before use
  lpt_sync #(
    .W(10)
  ) u_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .d_i({lclk_i, lframe_n_i, lreset_n_i, lpcpd_n_i, clkrun_n_i, main_rail_rst_n_i, lad_i}),
    .q_o({lclk_s, lframe_n_s, lreset_n_s, lpcpd_n_s, clkrun_n_s, rail_n_s, lad_s})
  );

  // host drives lad on the rising edge, so the falling edge sees it stable
  assign lclk_rise = lclk_s & ~r_r.lclk_d;
  assign lclk_fall = ~lclk_s & r_r.lclk_d;
  // power-down is only a local power-good for the bus side
  assign bus_rst_now = ~lreset_n_s | ~lpcpd_n_s | ~rail_n_s;
  assign sirq_en = serial_irq_enable_setting_i;
  // irq lines are compared on clock_i, never on lclk
  assign change = (irq_i != r_r.irq_d) | (drq_i & ~r_r.drq_d);

  always_comb
  begin
    r_nxt = r_r;
    r_nxt.lclk_d = lclk_s;
    r_nxt.bus_rst = bus_rst_now;
    r_nxt.irq_d = irq_i;
    r_nxt.drq_d = drq_i;

    if (r_r.req_valid && rsp_done_i)
    begin
      r_nxt.req_valid = 1'b0;
      r_nxt.done = 1'b1;
      r_nxt.rdata = rsp_rdata_i;
    end

    if (lclk_fall)
    begin
      if (!lframe_n_s)
      begin
        // a frame start aborts whatever ran before
        r_nxt.lad_oe = 1'b0;
        r_nxt.req_valid = 1'b0;
        r_nxt.done = 1'b0;
        r_nxt.st = (lad_s == LAD_START) ? LPT_CYC : LPT_IDLE;
      end
      else
      begin
        case (r_r.st)
          LPT_CYC:
          begin
            if (cyc_supported(lad_s))
            begin
              r_nxt.mem = (lad_s[3:2] == CYC_MEM);
              r_nxt.wr = lad_s[CYC_DIR_BIT];
              r_nxt.cnt = '0;
              r_nxt.addr = '0;
              r_nxt.st = LPT_ADDR;
            end
            else
            begin
              r_nxt.st = LPT_SKIP;
            end
          end
          LPT_ADDR:
          begin
            r_nxt.addr = {r_r.addr[27:0], lad_s};
            r_nxt.cnt = r_r.cnt + 3'h1;
            if (r_r.cnt == addr_last(r_r.mem))
            begin
              r_nxt.cnt = '0;
              r_nxt.st = r_r.wr ? LPT_WDATA : LPT_TAR_H;
            end
          end
          LPT_WDATA:
          begin
            if (r_r.cnt == '0)
            begin
              r_nxt.wdata[3:0] = lad_s;
            end
            else
            begin
              r_nxt.wdata[7:4] = lad_s;
            end
            r_nxt.cnt = r_r.cnt + 3'h1;
            if (r_r.cnt == DATA_LAST)
            begin
              r_nxt.cnt = '0;
              r_nxt.st = LPT_TAR_H;
            end
          end
          LPT_TAR_H:
          begin
            r_nxt.cnt = r_r.cnt + 3'h1;
            if (r_r.cnt == TAR_LAST)
            begin
              r_nxt.cnt = '0;
              if (claim_i)
              begin
                r_nxt.st = LPT_SYNC;
                r_nxt.lad = LAD_SYNC_LWAIT;
                r_nxt.lad_oe = 1'b1;
                r_nxt.waits = 4'h1;
                r_nxt.req_valid = 1'b1;
                r_nxt.done = 1'b0;
              end
              else
              begin
                r_nxt.st = LPT_SKIP;
              end
            end
          end
          LPT_SYNC:
          begin
            if (r_r.waits >= WAIT_MIN && (r_r.done || r_r.waits >= WAIT_MAX))
            begin
              // no error sync exists here: a stuck access reads all ones
              if (!r_r.done)
              begin
                r_nxt.req_valid = 1'b0;
                r_nxt.rdata = RDATA_TIMEOUT;
              end
              r_nxt.done = 1'b0;
              r_nxt.lad = LAD_SYNC_READY;
              r_nxt.st = r_r.wr ? LPT_TAR_D : LPT_RDATA;
            end
            else
            begin
              r_nxt.lad = LAD_SYNC_LWAIT;
              r_nxt.waits = r_r.waits + 4'h1;
            end
          end
          LPT_RDATA:
          begin
            r_nxt.lad = (r_r.cnt == '0) ? r_r.rdata[3:0] : r_r.rdata[7:4];
            r_nxt.cnt = r_r.cnt + 3'h1;
            if (r_r.cnt == DATA_LAST)
            begin
              r_nxt.cnt = '0;
              r_nxt.st = LPT_TAR_D;
            end
          end
          LPT_TAR_D:
          begin
            r_nxt.cnt = r_r.cnt + 3'h1;
            r_nxt.lad = LAD_TAR;
            if (r_r.cnt == TAR_LAST)
            begin
              r_nxt.cnt = '0;
              r_nxt.lad_oe = 1'b0;
              r_nxt.st = LPT_IDLE;
            end
          end
          default:
          begin
          end
        endcase
      end
    end

    // pending change survives bus resets; the new event beats the clear
    if (irq_delivered_i)
    begin
      r_nxt.pending = 1'b0;
    end
    if (change)
    begin
      r_nxt.pending = 1'b1;
    end

    if (lclk_rise)
    begin
      // pin high means the clock is stopped or stopping
      if (clkrun_n_s)
      begin
        r_nxt.ck_hi = (r_r.ck_hi == CK_IDLE_CLOCKS) ? r_r.ck_hi : r_r.ck_hi + 2'h1;
      end
      else
      begin
        r_nxt.ck_hi = '0;
      end
    end

    if (r_r.ck_drive)
    begin
      if (lclk_rise)
      begin
        r_nxt.ck_edges = r_r.ck_edges + 2'h1;
        if (r_r.ck_edges == CK_HOLD_EDGES - 2'h1)
        begin
          r_nxt.ck_drive = 1'b0;
          r_nxt.ck_edges = '0;
        end
      end
    end
    else if (r_r.pending && sirq_en && clkrun_n_s && r_r.ck_hi == CK_IDLE_CLOCKS)
    begin
      r_nxt.ck_drive = 1'b1;
      r_nxt.ck_edges = '0;
    end

    r_nxt.sq_val = serirq_value_i;
    r_nxt.sq_oe = serirq_drive_i & sirq_en;

    if (!sirq_en)
    begin
      r_nxt.ck_drive = 1'b0;
    end
    if (bus_rst_now)
    begin
      // only bus side state; the pending change is kept
      r_nxt.st = LPT_IDLE;
      r_nxt.lad_oe = 1'b0;
      r_nxt.req_valid = 1'b0;
      r_nxt.done = 1'b0;
      r_nxt.ck_drive = 1'b0;
      r_nxt.ck_edges = '0;
      r_nxt.sq_oe = 1'b0;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      r_r <= '0;
    end
    else
    begin
      r_r <= r_nxt;
    end
  end

  assign lad_o = r_r.lad;
  assign lad_oe_o = r_r.lad_oe;
  assign clkrun_n_o = 1'b0;
  assign clkrun_n_oe_o = r_r.ck_drive;
  assign serirq_o = r_r.sq_val;
  assign serirq_oe_o = r_r.sq_oe;
  assign req_valid_o = r_r.req_valid;
  assign req_write_o = r_r.wr;
  assign req_mem_o = r_r.mem;
  assign req_addr_o = r_r.addr;
  assign req_wdata_o = r_r.wdata;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  a_sync_codes: assert property ((r_r.st == LPT_SYNC && lad_oe_o)
    |-> (lad_o == LAD_SYNC_LWAIT && lad_o != LAD_SYNC_SWAIT))
    else $error("sync phase drove a code other than long wait");
  // read data nibbles may carry any value, the last one stands while tar starts
  a_no_error: assert property ((lad_oe_o && r_r.st != LPT_RDATA
    && !(r_r.st == LPT_TAR_D && r_r.cnt == '0 && !r_r.wr)) |-> lad_o != LAD_SYNC_ERR)
    else $error("error sync code driven");
  a_min_waits: assert property ((r_r.st == LPT_SYNC && r_nxt.st != LPT_SYNC && !bus_rst_now
    && lframe_n_s) |=> lad_o == LAD_SYNC_READY && $past(r_r.waits) >= WAIT_MIN)
    else $error("ready sync before two waits");
  a_max_waits: assert property (r_r.st == LPT_SYNC |-> r_r.waits <= WAIT_MAX)
    else $error("more than eight wait states");
  a_bus_float: assert property (bus_rst_now |=> !lad_oe_o && !clkrun_n_oe_o && !serirq_oe_o)
    else $error("pins driven during bus reset");
  a_ck_disabled: assert property (!sirq_en |=> !clkrun_n_oe_o)
    else $error("clock-run driven while serial irq disabled");
  a_ck_start: assert property ($rose(clkrun_n_oe_o)
    |-> $past(clkrun_n_s) && $past(r_r.ck_hi) == CK_IDLE_CLOCKS && $past(r_r.pending))
    else $error("clock-run driven without idle history");
  a_ck_release: assert property (($fell(clkrun_n_oe_o) && !$past(bus_rst_now) && $past(sirq_en))
    |-> $past(lclk_rise) && $past(r_r.ck_edges) == CK_HOLD_EDGES - 2'h1)
    else $error("clock-run released before two rising edges");
  a_pending_kept: assert property ((r_r.pending && !irq_delivered_i) or change |=> r_r.pending)
    else $error("pending change lost");
  a_skip_other: assert property ((lclk_fall && lframe_n_s && !bus_rst_now && r_r.st == LPT_CYC
    && !cyc_supported(lad_s)) |=> r_r.st == LPT_SKIP)
    else $error("unsupported cycle not ignored");
  a_unclaimed: assert property ((lclk_fall && lframe_n_s && !bus_rst_now && r_r.st == LPT_TAR_H
    && r_r.cnt == TAR_LAST && !claim_i) |=> r_r.st == LPT_SKIP && !lad_oe_o)
    else $error("unclaimed cycle answered");

endmodule : lpt_target

`default_nettype wire

// [tb/lpt_host.sv]
`timescale 1ns/10ps
`default_nettype none

module lpt_host (
  // link wires
  output logic lclk_o,
  output logic lframe_n_o,
  output logic [3:0] lad_o,
  output logic clkrun_n_o,
  // device drivers
  input wire logic [3:0] dlad_i,
  input wire logic dlad_oe_i,
  input wire logic dck_oe_i
);
  logic [3:0] h_lad = 4'hf;
  logic h_oe = 1'b0;
  logic clk_on = 1'b0;
  logic gen_low = 1'b1;
  int n_rise = 0;

  // released lines float to their pull-ups
  assign lad_o = dlad_oe_i ? dlad_i : (h_oe ? h_lad : 4'hf);
  assign clkrun_n_o = !(dck_oe_i || gen_low);

  initial
  begin
    lclk_o = 1'b0;
    lframe_n_o = 1'b1;
    #7 clk_on = 1'b1;
  end

  // a period is always finished, so the clock stops low
  always
  begin
    if (clk_on)
    begin
      #160 lclk_o = 1'b1;
      n_rise++;
      #160 lclk_o = 1'b0;
    end
    else
      @(clk_on);
  end

  // slow answer to a restart request on the released line
  always @(negedge clkrun_n_o)
    if (!gen_low)
    begin
      #407;
      gen_low = 1'b1;
      clk_on = 1'b1;
    end

  task automatic stop_clk();
    gen_low = 1'b0;
    repeat (4) @(posedge lclk_o);
    #1 clk_on = gen_low;
  endtask : stop_clk

  // host drives on rising edges, reads the device at falling edges
  task automatic cycle(input logic [3:0] ct, input logic [31:0] a, input logic [7:0] wd,
                       output logic [7:0] rd, output int waits, output bit ans, output bit bad);
    logic [3:0] q[$];
    q = {ct};
    for (int i = (ct[2] ? 7 : 3); i >= 0; i--)
      q.push_back(a[4*i +: 4]);
    if (ct[1])
      q = {q, wd[3:0], wd[7:4]};
    q.push_back(4'hf);
    @(posedge lclk_o);
    lframe_n_o <= 1'b0;
    h_oe <= 1'b1;
    h_lad <= 4'h0;
    foreach (q[i])
    begin
      @(posedge lclk_o);
      lframe_n_o <= 1'b1;
      h_lad <= q[i];
    end
    @(posedge lclk_o);
    h_oe <= 1'b0;
    rd = 8'h00;
    waits = 0;
    repeat (2) @(negedge lclk_o);
    ans = dlad_oe_i;
    while (ans && lad_o === 4'h6 && waits < 12)
    begin
      waits++;
      @(negedge lclk_o);
    end
    bad = ans && lad_o !== 4'h0;
    if (ans && !ct[1])
    begin
      @(negedge lclk_o);
      rd[3:0] = lad_o;
      @(negedge lclk_o);
      rd[7:4] = lad_o;
    end
    if (ans)
    begin
      @(negedge lclk_o);
      bad = bad || lad_o !== 4'hf || !dlad_oe_i;
      @(negedge lclk_o);
      bad = bad || dlad_oe_i;
    end
  endtask : cycle
endmodule : lpt_host

`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/10ps
`default_nettype none

module testbench;
  logic clk = 1'b0, rst = 1'b1, lreset_n = 1'b1, lpcpd_n = 1'b1, rail_n = 1'b1;
  logic en = 1'b0, drq = 1'b0, dlv = 1'b0, sdrv = 1'b0, claim = 1'b1, done = 1'b0;
  logic [15:0] irq = 16'h0000;
  wire lclk, lframe_n, clkrun_n;
  wire [3:0] lad;
  logic [3:0] lad_d;
  logic lad_oe, ck_oe, sirq_oe, sirq_v, rvalid, rwrite, rmem, c_wr, c_mem;
  logic [31:0] raddr, c_addr;
  logic [7:0] rwdata, c_wd, rd;
  int delay = 2, busy = 0, w, err_total = 0, n_tests = 0;
  bit ans, bad;

  always #20 clk = ~clk;

  lpt_host u_host (.lclk_o(lclk), .lframe_n_o(lframe_n), .lad_o(lad), .clkrun_n_o(clkrun_n),
    .dlad_i(lad_d), .dlad_oe_i(lad_oe), .dck_oe_i(ck_oe));

  lpt_target u_dut (.clock_i(clk), .rst_i(rst), .lclk_i(lclk), .lframe_n_i(lframe_n),
    .lreset_n_i(lreset_n), .lpcpd_n_i(lpcpd_n), .lad_i(lad), .lad_o(lad_d),
    .lad_oe_o(lad_oe), .clkrun_n_i(clkrun_n), .clkrun_n_o(), .clkrun_n_oe_o(ck_oe),
    .serirq_o(sirq_v), .serirq_oe_o(sirq_oe), .main_rail_rst_n_i(rail_n),
    .serial_irq_enable_setting_i(en), .irq_i(irq), .drq_i(drq), .irq_delivered_i(dlv),
    .serirq_drive_i(sdrv), .serirq_value_i(1'b1), .req_valid_o(rvalid),
    .req_write_o(rwrite), .req_mem_o(rmem), .req_addr_o(raddr), .req_wdata_o(rwdata),
    .claim_i(claim), .rsp_done_i(done), .rsp_rdata_i(8'ha5));

  // internal side answers after delay cycles; a huge delay lets the access stall
  always @(negedge clk)
  begin
    done <= rvalid === 1'b1 && busy == delay;
    busy <= (rvalid === 1'b1) ? busy + 1 : 0;
    if (rvalid === 1'b1 && busy == 0)
    begin
      c_addr <= raddr;
      c_wr <= rwrite;
      c_mem <= rmem;
      c_wd <= rwdata;
    end
  end

  task automatic chk(input bit ok, input string m);
    n_tests++;
    if (!ok)
    begin
      err_total++;
      $display("Error %0t: %s", $time, m);
    end
  endtask : chk

  task automatic wrap_up();
    if (err_total == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  task automatic pulse_dlv();
    tick(1);
    dlv <= 1'b1;
    tick(1);
    dlv <= 1'b0;
  endtask : pulse_dlv

  task automatic ck_wait(input logic v);
    for (int k = 0; k < 200 && ck_oe !== v; k++)
      tick(1);
  endtask : ck_wait

  task automatic xfer(input logic [3:0] ct, input logic [31:0] a);
    u_host.cycle(ct, a, 8'h3c, rd, w, ans, bad);
  endtask : xfer

  task automatic t_access();
    logic [3:0] ct;
    logic [31:0] a;
    for (int i = 0; i < 4; i++)
    begin
      ct = 4'(2 * i);
      a = 32'h8123_4560 + 32'(i);
      xfer(ct, a);
      chk(ans && !bad && w >= 2 && w <= 8, "sync sequence");
      chk(c_mem === ct[2] && c_wr === ct[1], "request kind");
      chk(c_addr === (ct[2] ? a : {16'h0000, a[15:0]}), "request address");
      chk(ct[1] ? c_wd === 8'h3c : rd === 8'ha5, "data byte");
    end
    delay = 40;
    xfer(4'h0, 32'h0000_002e);
    chk(ans && !bad && w >= 4 && w <= 8, "slow access waits");
    delay = 1000;
    xfer(4'h4, 32'h000f_3000);
    chk(ans && !bad && w == 8 && rd === 8'hff, "stalled access");
    delay = 2;
  endtask : t_access

  task automatic t_refuse();
    xfer(4'h8, 32'h0000_0060);
    chk(!ans, "unsupported cycle answered");
    tick(1);
    claim <= 1'b0;
    xfer(4'h0, 32'h0000_0060);
    chk(!ans, "unclaimed cycle answered");
    tick(1);
    claim <= 1'b1;
    xfer(4'h2, 32'h0000_0061);
    chk(ans && !bad && c_wd === 8'h3c, "access after refusal");
  endtask : t_refuse

  task automatic t_pd();
    tick(1);
    en <= 1'b1;
    sdrv <= 1'b1;
    tick(8);
    chk(sirq_oe === 1'b1 && sirq_v === 1'b1, "serial irq pin not enabled");
    for (int s = 0; s < 3; s++)
    begin
      lreset_n <= s != 0;
      lpcpd_n <= s != 1;
      rail_n <= s != 2;
      tick(8);
      chk(lad_oe === 1'b0 && sirq_oe === 1'b0 && ck_oe === 1'b0, "pins driven");
      if (s == 1)
      begin
        // no frames while powered down; the clock stops only after the lead time
        #30007 u_host.clk_on = 1'b0;
        #2000 u_host.clk_on = 1'b1;
        tick(1);
      end
      {lreset_n, lpcpd_n, rail_n} <= 3'b111;
      tick(8);
    end
    xfer(4'h0, 32'h0000_0062);
    chk(ans && !bad && rd === 8'ha5, "access after power-down");
  endtask : t_pd

  task automatic t_ck();
    int r0;
    tick(1);
    en <= 1'b0;
    u_host.stop_clk();
    tick(4);
    irq <= 16'h0008;
    tick(40);
    chk(ck_oe === 1'b0 && sirq_oe === 1'b0, "driven while disabled");
    pulse_dlv();
    en <= 1'b1;
    tick(4);
    irq <= 16'h0000;
    ck_wait(1'b1);
    chk(ck_oe === 1'b1, "no restart on falling irq");
    r0 = u_host.n_rise;
    ck_wait(1'b0);
    chk(u_host.n_rise - r0 == 2 && ck_oe === 1'b0, "hold length");
    irq <= 16'h0100;
    tick(40);
    chk(ck_oe === 1'b0, "driven over a low line");
    fork
      u_host.stop_clk();
    join_none
    @(posedge lclk);
    @(negedge lclk);
    chk(ck_oe === 1'b0, "driven after one idle clock");
    ck_wait(1'b1);
    chk(ck_oe === 1'b1, "pending change not retried");
    ck_wait(1'b0);
    pulse_dlv();
    tick(100);
    u_host.stop_clk();
    tick(40);
    chk(ck_oe === 1'b0, "driven after delivery");
    drq <= 1'b1;
    ck_wait(1'b1);
    chk(ck_oe === 1'b1, "no restart on dma request");
    ck_wait(1'b0);
    pulse_dlv();
  endtask : t_ck

  initial
  begin
    tick(20);
    rst <= 1'b0;
    tick(10);
    t_access();
    t_refuse();
    t_pd();
    t_ck();
    wrap_up();
  end

  // the whole run needs well under half of this span
  initial
  begin
    #1000000;
    err_total++;
    wrap_up();
  end
endmodule : testbench

`default_nettype wire
